// File: design/didpg_pkg.sv
// Package for the display-ID pair generator: widths, FIFO geometry, carriers.
// Assumes a single half-pixel-clock domain shared by all users.
package didpg_pkg;

   localparam int ID_WIDTH       = 5;
   localparam int X_WIDTH        = 11;
   localparam int DUR_WIDTH      = 11;
   localparam int PAIR_WIDTH     = 2 * ID_WIDTH;
   localparam int ENTRY_WIDTH    = PAIR_WIDTH + DUR_WIDTH;
   localparam int FIFO_DEPTH     = 64;
   localparam int FIFO_AW        = 6;
   localparam int OUT_PIPE       = 2;

   localparam logic [DUR_WIDTH-1:0] DUR_ONE   = 11'h001;
   localparam logic [DUR_WIDTH-1:0] DUR_ZERO  = 11'h000;
   localparam logic [ID_WIDTH-1:0]  ID_ZERO   = 5'h00;
   localparam logic [X_WIDTH-1:0]   X_ZERO    = 11'h000;
   localparam logic [X_WIDTH-1:0]   X_ONE     = 11'h001;

   // Transition record as loaded by the master controller
   typedef struct packed {
      logic [X_WIDTH-1:0]  x_location;
      logic [ID_WIDTH-1:0] id_value;
   } didpg_record_type;

   // Display-ID pair, odd pixel in the upper half
   typedef struct packed {
      logic [ID_WIDTH-1:0] odd_pixel_id;
      logic [ID_WIDTH-1:0] even_pixel_id;
   } didpg_pair_type;

   // FIFO entry: pair plus duration
   typedef struct packed {
      didpg_pair_type       pair;
      logic [DUR_WIDTH-1:0] duration;
   } didpg_entry_type;

endpackage : didpg_pkg

// File: design/didpg_fifo.sv
// 64x21 FIFO with separate write/read address counters and a depth counter.
// Assumes same-clock writer and reader; flush clears all counters.
`timescale 1ns/1ps
module didpg_fifo #(
   parameter int WIDTH = didpg_pkg::ENTRY_WIDTH,
   parameter int DEPTH = didpg_pkg::FIFO_DEPTH,
   parameter int AW    = didpg_pkg::FIFO_AW
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             resetn,
   // Control
   input  wire logic             flush,
   // Write side
   input  wire logic             wr_en,
   input  wire logic [WIDTH-1:0] wr_data,
   // Read side
   input  wire logic             rd_en,
   output logic      [WIDTH-1:0] rd_data,
   // Status
   output logic                  full,
   output logic                  empty
);

   initial begin
      if (DEPTH != (1 << AW)) $error("didpg_fifo: DEPTH must be 2**AW");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_addr_reg;
   logic [AW-1:0]    rd_addr_reg;
   logic [AW:0]      depth_reg;
   logic [AW:0]      depth_next;
   wire              do_wr = wr_en && !full;
   wire              do_rd = rd_en && !empty;

   assign full    = (depth_reg == (AW+1)'(DEPTH));
   assign empty   = (depth_reg == '0);
   assign rd_data = mem[rd_addr_reg];

   always_comb begin
      depth_next = depth_reg;
      if (do_wr && !do_rd) depth_next = depth_reg + 1'b1;
      if (do_rd && !do_wr) depth_next = depth_reg - 1'b1;
   end

   always_ff @(posedge mclk) begin
      if (do_wr) mem[wr_addr_reg] <= wr_data;
   end

   // Counters clear on reset and on flush
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wr_addr_reg <= '0;
         rd_addr_reg <= '0;
         depth_reg   <= '0;
      end else if (flush) begin
         wr_addr_reg <= '0;
         rd_addr_reg <= '0;
         depth_reg   <= '0;
      end else begin
         if (do_wr) wr_addr_reg <= wr_addr_reg + 1'b1;
         if (do_rd) rd_addr_reg <= rd_addr_reg + 1'b1;
         depth_reg <= depth_next;
      end
   end

endmodule : didpg_fifo

// File: design/didpg_top.sv
// Display-ID pair generator: record conversion, FIFO, duration countdown, output pipe.
// Assumes one half-pixel clock; the master controller answers fill requests with load strobes.
//
// Operation
// - Converted entries held in a 64x21 FIFO with address and depth counters.
// - While FIFO not full, controller fetches next record into conversion registers.
// - Write address advances once per FIFO write, zero to two per record.
// - Popped entry loads pair register with IDs and counter with duration.
// - Counter decrements each cycle; at one, pop next entry and advance read address.
// - Pair outputs pass through extra pipeline registers after the pair register.
// - Record ID applies from its X location to the next record's location.
// - Even pixel ID is low half of the pair, odd pixel ID high half.
// - Loading next-record registers shifts old contents into current-record registers.
// - Loading a new record itself starts conversion of the current record.
// - Conversion takes two cycles and yields zero, one or two entries.
// - First cycle: duration is difference of bits 10:1; both IDs current ID.
// - First-cycle write only when that half-pixel difference is nonzero.
// - Second cycle: duration one, current and next ID; written if next X odd.
// - Odd next location is incremented before becoming the current location.
// - Equal locations after increment produce no entry.
// - Durations count half-pixel cycles; one pair output per cycle.
// - IDs driven only while visible-line channel high, 2 + OUT_PIPE cycles later.
// - End-of-field channel flushes FIFO and starts end-of-field processing.
// - Fill request raised while generation enabled and FIFO not full.
`timescale 1ns/1ps
module didpg_top #(
   parameter int OUT_PIPE = didpg_pkg::OUT_PIPE
) (
   // Clock and reset
   input  wire logic                           mclk,
   input  wire logic                           resetn,
   // Control and timing channels
   input  wire logic                           gen_enable,
   input  wire logic                           visible_line_channel,
   input  wire logic                           end_of_field_channel,
   // Master controller side
   output logic                                fill_request,
   output logic                                eof_request,
   input  wire logic                           record_load,
   input  wire didpg_pkg::didpg_record_type    record_data,
   // Pixel mapping side
   output logic [didpg_pkg::ID_WIDTH-1:0]      even_pixel_id,
   output logic [didpg_pkg::ID_WIDTH-1:0]      odd_pixel_id
);

   initial begin
      if (OUT_PIPE < 1) $error("didpg_top: OUT_PIPE must be at least 1");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Conversion states
   typedef enum logic [2:0] {
      CONV_IDLE   = 3'b001,
      CONV_FIRST  = 3'b010,
      CONV_SECOND = 3'b100
   } didpg_conv_type;

   didpg_conv_type conv_reg;
   didpg_conv_type conv_next;

   // Conversion input registers
   logic [didpg_pkg::X_WIDTH-1:0]  current_x_location_reg;
   logic [didpg_pkg::ID_WIDTH-1:0] current_id_value_reg;
   logic [didpg_pkg::X_WIDTH-1:0]  next_x_location_reg;
   logic [didpg_pkg::ID_WIDTH-1:0] next_id_value_reg;

   // Converted entry register and write strobe
   didpg_pkg::didpg_entry_type     conv_entry_reg;
   logic                           conv_write_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Half-pixel difference of bits 10:1
   function automatic logic [didpg_pkg::DUR_WIDTH-1:0] half_diff(
      input logic [didpg_pkg::X_WIDTH-1:0] x_hi,
      input logic [didpg_pkg::X_WIDTH-1:0] x_lo
   );
      logic [didpg_pkg::X_WIDTH-2:0] d;
      d = x_hi[didpg_pkg::X_WIDTH-1:1] - x_lo[didpg_pkg::X_WIDTH-1:1];
      half_diff = {1'b0, d};
   endfunction : half_diff

   ////////////////////////////////////////////////////////////////////////////
   // Synchronisers for the timing channels
   logic vis_meta_reg;
   logic vis_sync_reg;
   logic eof_meta_reg;
   logic eof_sync_reg;
   logic eof_prev_reg;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         vis_meta_reg <= 1'b0;
         vis_sync_reg <= 1'b0;
         eof_meta_reg <= 1'b0;
         eof_sync_reg <= 1'b0;
         eof_prev_reg <= 1'b0;
      end else begin
         vis_meta_reg <= visible_line_channel;
         vis_sync_reg <= vis_meta_reg;
         eof_meta_reg <= end_of_field_channel;
         eof_sync_reg <= eof_meta_reg;
         eof_prev_reg <= eof_sync_reg;
      end
   end

   wire eof_rise = eof_sync_reg && !eof_prev_reg;

   // End-of-field flush and processing request
   assign eof_request = eof_rise;

   ////////////////////////////////////////////////////////////////////////////
   // FIFO
   logic                       fifo_full;
   logic                       fifo_empty;
   logic                       fifo_pop;
   didpg_pkg::didpg_entry_type fifo_rd_entry;

   didpg_fifo #(
      .WIDTH (didpg_pkg::ENTRY_WIDTH),
      .DEPTH (didpg_pkg::FIFO_DEPTH),
      .AW    (didpg_pkg::FIFO_AW)
   ) u_fifo (
      .mclk    (mclk),
      .resetn  (resetn),
      .flush   (eof_rise),
      .wr_en   (conv_write_reg),
      .wr_data (conv_entry_reg),
      .rd_en   (fifo_pop),
      .rd_data (fifo_rd_entry),
      .full    (fifo_full),
      .empty   (fifo_empty)
   );

   // Fill request to the master controller
   assign fill_request = gen_enable && !fifo_full;

   ////////////////////////////////////////////////////////////////////////////
   // Record pipeline and conversion sequencer
   wire new_record = record_load && !eof_rise;
   wire next_is_odd = next_x_location_reg[0];

   // Current location after increment when next was odd
   wire [didpg_pkg::X_WIDTH-1:0] next_as_current =
      next_is_odd ? next_x_location_reg + didpg_pkg::X_ONE : next_x_location_reg;

   wire [didpg_pkg::DUR_WIDTH-1:0] first_duration =
      half_diff(next_x_location_reg, current_x_location_reg);

   always_comb begin
      conv_next = conv_reg;
      case (conv_reg)
         CONV_IDLE:   if (new_record) conv_next = CONV_FIRST;
         CONV_FIRST:  conv_next = CONV_SECOND;
         CONV_SECOND: conv_next = new_record ? CONV_FIRST : CONV_IDLE;
         default:     conv_next = CONV_IDLE;
      endcase
      if (eof_rise) conv_next = CONV_IDLE;
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         conv_reg               <= CONV_IDLE;
         current_x_location_reg <= didpg_pkg::X_ZERO;
         current_id_value_reg   <= didpg_pkg::ID_ZERO;
         next_x_location_reg    <= didpg_pkg::X_ZERO;
         next_id_value_reg      <= didpg_pkg::ID_ZERO;
      end else begin
         conv_reg <= conv_next;
         if (new_record) begin
            current_x_location_reg <= next_as_current;
            current_id_value_reg   <= next_id_value_reg;
            next_x_location_reg    <= record_data.x_location;
            next_id_value_reg      <= record_data.id_value;
         end
      end
   end

   // Entry generation, one write opportunity per conversion cycle
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         conv_entry_reg <= '0;
         conv_write_reg <= 1'b0;
      end else begin
         conv_write_reg <= 1'b0;
         case (conv_reg)
            CONV_FIRST: begin
               conv_entry_reg.duration           <= first_duration;
               conv_entry_reg.pair.even_pixel_id <= current_id_value_reg;
               conv_entry_reg.pair.odd_pixel_id  <= current_id_value_reg;
               conv_write_reg <= (first_duration != didpg_pkg::DUR_ZERO)
                                 && !eof_rise;
            end
            CONV_SECOND: begin
               conv_entry_reg.duration           <= didpg_pkg::DUR_ONE;
               conv_entry_reg.pair.even_pixel_id <= current_id_value_reg;
               conv_entry_reg.pair.odd_pixel_id  <= next_id_value_reg;
               conv_write_reg <= next_is_odd && !eof_rise;
            end
            default: begin
               conv_write_reg <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read side: duration countdown and pair register
   logic [didpg_pkg::DUR_WIDTH-1:0] duration_count_reg;
   didpg_pkg::didpg_pair_type       pair_reg;
   logic                            pair_valid_reg;

   // Pop when the current pair has run out
   wire run_done = !pair_valid_reg || (duration_count_reg <= didpg_pkg::DUR_ONE);
   assign fifo_pop = run_done && !fifo_empty && !eof_rise;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         duration_count_reg <= didpg_pkg::DUR_ZERO;
         pair_reg           <= '0;
         pair_valid_reg     <= 1'b0;
      end else if (eof_rise) begin
         duration_count_reg <= didpg_pkg::DUR_ZERO;
         pair_valid_reg     <= 1'b0;
      end else if (fifo_pop) begin
         pair_reg           <= fifo_rd_entry.pair;
         duration_count_reg <= fifo_rd_entry.duration;
         pair_valid_reg     <= 1'b1;
      end else if (pair_valid_reg) begin
         duration_count_reg <= duration_count_reg - 1'b1;
         if (duration_count_reg <= didpg_pkg::DUR_ONE) pair_valid_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output pipeline gated by the visible-line channel and a live run
   // Expired or flushed runs show zero IDs rather than the stale pair
   didpg_pkg::didpg_pair_type pipe_reg [OUT_PIPE];
   wire didpg_pkg::didpg_pair_type gated_pair =
      (vis_sync_reg && pair_valid_reg) ? pair_reg : '0;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < OUT_PIPE; i++) pipe_reg[i] <= '0;
      end else begin
         pipe_reg[0] <= gated_pair;
         for (int i = 1; i < OUT_PIPE; i++) pipe_reg[i] <= pipe_reg[i-1];
      end
   end

   assign even_pixel_id = pipe_reg[OUT_PIPE-1].even_pixel_id;
   assign odd_pixel_id  = pipe_reg[OUT_PIPE-1].odd_pixel_id;

endmodule : didpg_top

// File: testbench/didpg_monitor.sv
// Port checker for the display-ID pair generator.
// Assumes a bind to didpg_top, one clock, async active-low reset.
`timescale 1ns/1ps
module didpg_monitor #(
   parameter int OUT_PIPE = didpg_pkg::OUT_PIPE
) (
   // Clock and reset
   input wire logic                        mclk,
   input wire logic                        resetn,
   // Control and timing
   input wire logic                        gen_enable,
   input wire logic                        visible_line_channel,
   input wire logic                        end_of_field_channel,
   // Controller side
   input wire logic                        fill_request,
   input wire logic                        eof_request,
   input wire logic                        record_load,
   input wire didpg_pkg::didpg_record_type record_data,
   // Pixel side
   input wire logic [4:0]                  even_pixel_id,
   input wire logic [4:0]                  odd_pixel_id
);
   default clocking mon_cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   wire ids_zero = even_pixel_id == 5'h00 && odd_pixel_id == 5'h00;
   ////////////////////////////////////////
   sequence eof_rise_s;
      !end_of_field_channel ##1 end_of_field_channel;
   endsequence
   sequence dark_line_s;
      !visible_line_channel [*6];
   endsequence
   ////////////////////////////////////////
   fill_gate_a: assert property (!gen_enable |-> !fill_request) else $error("fill while disabled");
   eof_pulse_a: assert property (eof_rise_s |-> ##[1:4] eof_request) else $error("no eof pulse");
   eof_single_a: assert property (eof_request |=> !eof_request) else $error("eof pulse too long");
   eof_cause_a: assert property (eof_request |-> $past(end_of_field_channel, 2)) else $error("stray eof");
   eof_flush_a: assert property (eof_request |-> ##[1:6] ids_zero) else $error("ids kept after flush");
   dark_ids_a: assert property (dark_line_s |-> ids_zero) else $error("ids outside line");
   reset_ids_a: assert property ($rose(resetn) |-> ids_zero) else $error("ids after reset");
   fill_drop_a: assert property ($fell(fill_request) && gen_enable && $past(gen_enable) |->
      $past(record_load, 1) || $past(record_load, 2) || $past(record_load, 3) || $past(record_load, 4))
      else $error("fill fell without load");
endmodule : didpg_monitor

bind didpg_top didpg_monitor #(.OUT_PIPE(OUT_PIPE)) mon_u (.mclk, .resetn, .gen_enable, .visible_line_channel,
   .end_of_field_channel, .fill_request, .eof_request, .record_load, .record_data, .even_pixel_id, .odd_pixel_id);

// File: testbench/didpg_pixel_sink.sv
// Pixel mapping sink: records runs of nonzero display-ID pairs.
// Assumes pairs are sampled on the rising half-pixel clock edge.
`timescale 1ns/1ps
module didpg_pixel_sink (
   // Clock and reset
   input wire logic       mclk,
   input wire logic       resetn,
   // Capture control
   input wire logic       capture,
   // Pair from the generator
   input wire logic [4:0] even_pixel_id,
   input wire logic [4:0] odd_pixel_id
);
   didpg_pkg::didpg_pair_type run_pair [$];
   int                        run_len [$];
   didpg_pkg::didpg_pair_type pair_now;
   assign pair_now = {odd_pixel_id, even_pixel_id};
   always @(posedge mclk) begin
      if (!capture || !resetn) begin
         run_pair.delete();
         run_len.delete();
      end else if (pair_now != 10'h000) begin
         if (run_pair.size() > 0 && run_pair[$] == pair_now) begin
            run_len[$] = run_len[$] + 1;
         end else begin
            run_pair.push_back(pair_now);
            run_len.push_back(1);
         end
      end
   end
endmodule : didpg_pixel_sink

// File: testbench/test_didpg_top.sv
// Self-checking bench for the display-ID pair generator.
// Assumes the pixel sink model and the bound port checker.
`timescale 1ns/1ps
module test_didpg_top;
   logic                        mclk, resetn, gen_enable, visible_line_channel, end_of_field_channel;
   logic                        fill_request, eof_request, record_load, capture;
   didpg_pkg::didpg_record_type record_data;
   logic [4:0]                  even_pixel_id, odd_pixel_id;
   int                          err_total, check_count;
   ////////////////////////////////////////
   didpg_top #(.OUT_PIPE(2)) dut_u (.mclk, .resetn, .gen_enable, .visible_line_channel, .end_of_field_channel,
      .fill_request, .eof_request, .record_load, .record_data, .even_pixel_id, .odd_pixel_id);
   didpg_pixel_sink sink_u (.mclk, .resetn, .capture, .even_pixel_id, .odd_pixel_id);
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   ////////////////////////////////////////
   task automatic check_pair(input logic [9:0] got, input logic [9:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t %s: got %h exp %h", $time, what, got, exp);
      end
   endtask : check_pair
   task automatic check_flag(input logic got, input logic exp, input string what);
      check_pair({9'h000, got}, {9'h000, exp}, what);
   endtask : check_flag
   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic wait_ids(input logic [9:0] exp, input string what);
      for (int i = 0; i < 12 && {odd_pixel_id, even_pixel_id} !== exp; i++) begin
         @(negedge mclk);
      end
      check_pair({odd_pixel_id, even_pixel_id}, exp, what);
      if ({odd_pixel_id, even_pixel_id} !== exp) begin
         tally_and_finish();
      end
   endtask : wait_ids
   task automatic load_rec(input logic [10:0] x, input logic [4:0] id);
      @(negedge mclk);
      record_load = 1'b1;
      record_data = '{x, id};
      @(negedge mclk);
      record_load = 1'b0;
      @(negedge mclk);
   endtask : load_rec
   ////////////////////////////////////////
   task automatic t_reset;
      repeat (2) @(negedge mclk);
      check_pair({odd_pixel_id, even_pixel_id}, 10'h000, "reset ids");
      check_flag(fill_request, 1'b0, "fill off");
      gen_enable = 1'b1;
      #1;
      check_flag(fill_request, 1'b1, "fill on");
      repeat (10) @(negedge mclk);
      resetn = 1'b1;
      $display("reset test done");
   endtask : t_reset
   task automatic t_convert;
      logic [9:0] exp_pair [6] = '{10'h021, 10'h042, 10'h063, 10'h083, 10'h0A5, 10'h0C6};
      int         exp_len [5] = '{20, 2, 1, 1, 6};
      capture = 1'b1;
      visible_line_channel = 1'b1;
      load_rec(11'h000, 5'h01);
      load_rec(11'h028, 5'h02);
      load_rec(11'h02C, 5'h03);
      load_rec(11'h02F, 5'h04);
      load_rec(11'h030, 5'h05);
      load_rec(11'h03C, 5'h06);
      load_rec(11'h064, 5'h07);
      repeat (30) @(negedge mclk);
      check_flag(sink_u.run_pair.size() >= 6, 1'b1, "run count");
      for (int i = 0; i < 6 && i < sink_u.run_pair.size(); i++) begin
         check_pair(sink_u.run_pair[i], exp_pair[i], "pair");
         if (i < 5) begin
            check_pair(10'(sink_u.run_len[i]), 10'(exp_len[i]), "run length");
         end
      end
      $display("convert test done");
   endtask : t_convert
   task automatic t_fill;
      int n;
      capture = 1'b0;
      load_rec(11'h064, 5'h01);
      load_rec(11'h44C, 5'h02);
      for (n = 0; n < 80 && fill_request === 1'b1; n++) begin
         load_rec(11'h44E + 11'(2 * n), 5'h03);
         repeat (2) @(negedge mclk);
      end
      check_pair(10'(n), 10'h040, "loads to full");
      wait_ids(10'h021, "long run");
      visible_line_channel = 1'b0;
      repeat (6) @(negedge mclk);
      check_pair({odd_pixel_id, even_pixel_id}, 10'h000, "blanked");
      visible_line_channel = 1'b1;
      wait_ids(10'h021, "unblanked");
      $display("fill test done");
   endtask : t_fill
   task automatic t_eof;
      int i;
      end_of_field_channel = 1'b1;
      for (i = 0; i < 8 && eof_request !== 1'b1; i++) begin
         @(negedge mclk);
      end
      check_flag(eof_request, 1'b1, "eof pulse");
      if (eof_request !== 1'b1) begin
         tally_and_finish();
      end
      wait_ids(10'h000, "flushed");
      repeat (4) @(negedge mclk);
      check_flag(fill_request, 1'b1, "refill");
      gen_enable = 1'b0;
      #1;
      check_flag(fill_request, 1'b0, "disabled");
      repeat (10) @(negedge mclk);
      end_of_field_channel = 1'b0;
      gen_enable = 1'b1;
      $display("eof test done");
   endtask : t_eof
   ////////////////////////////////////////
   initial begin
      resetn = 1'b0;
      gen_enable = 1'b0;
      visible_line_channel = 1'b0;
      end_of_field_channel = 1'b0;
      record_load = 1'b0;
      record_data = '0;
      capture = 1'b0;
      err_total = 0;
      check_count = 0;
      t_reset();
      t_convert();
      t_fill();
      t_eof();
      tally_and_finish();
   end
endmodule : test_didpg_top
